/* File: clkgen_i2c_pkg.sv */
package clkgen_i2c_pkg;

    // Bus addresses picked by the address strap
    localparam logic [6:0] ADDR_STRAP_LO = 7'h69;   // 1101001
    localparam logic [6:0] ADDR_STRAP_HI = 7'h6A;   // 1101010

    // Command byte layout
    localparam int         CMD_MODE_BIT  = 7;       // 1 = single byte mode

    // Register file size and power-up contents
    localparam int         REG_COUNT     = 8;
    localparam logic [7:0] REG_DEFAULTS [REG_COUNT] = '{
        8'hFF, 8'hF0, 8'h29, 8'hFF, 8'hF8, 8'h00, 8'h00, 8'h00
    };

    // Byte 1 low bits read back spread setting, not writable
    localparam int         RO_INDEX      = 1;
    localparam logic [7:0] RO_MASK       = 8'h03;

    // Byte count the device reports at the head of a block read
    localparam logic [7:0] BLOCK_READ_COUNT = 8'h07;

    // Bits per serial byte
    localparam logic [3:0] BYTE_BITS     = 4'h8;

endpackage

/* File: line_sync.sv */
`timescale 1ns/100ps

module line_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk_sys,   // System clock
    input  wire logic rst,       // Synchronous reset, high
    input  wire logic pin,       // Asynchronous pin level
    output logic      level,     // Synchronised level
    output logic      rise,      // One-cycle pulse on rising edge
    output logic      fall       // One-cycle pulse on falling edge
);

    logic meta_q;
    logic sync_q;
    logic last_q;

    // Two flops before use; the first is read only by the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
            last_q <= RESET_VAL;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // Edge pulses compare settled samples only
    assign level = sync_q;
    assign rise  = sync_q & ~last_q;
    assign fall  = ~sync_q & last_q;

endmodule // line_sync

/* File: clkgen_i2c_port.sv */
// Function
// - registers load defaults before any transfer
// - block bytes ascend, MSB first, stop anywhere
// - block read command top bit zero, acknowledged
// - read returns count seven, then data
// - block write starts at command low seven bits
// - command zero starts at register zero
// - device acknowledges every written byte
// - command top bit set means single byte
// - byte read: top bit, restart, read, nack
// - strap picks address 1101001 or 1101010
// - block read frame order as listed
// - byte read frame order as listed
// - port silent in power down or no power good
// - strap captured once, later changes ignored
`timescale 1ns/100ps

module clkgen_i2c_port
    import clkgen_i2c_pkg::*;
(
    input  wire logic                   clk_sys,         // 200 MHz clock
    input  wire logic                   rst,             // Sync reset, high
    input  wire logic                   scl_in,          // Serial clock pin
    input  wire logic                   sda_in,          // Serial data pin
    output logic                        sda_out,         // Data level, low
    output logic                        sda_oe_n,        // Low pulls data
    input  wire logic                   power_good_in,   // Power good pin
    input  wire logic                   bus_addr_strap,  // Address strap
    input  wire logic [1:0]             spread_readback, // Spread latch
    output logic [REG_COUNT*8-1:0]      reg_image,       // All registers
    output logic                        port_enabled,    // Port alive
    output logic [6:0]                  bus_addr         // Latched address
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_IGNORE
    } state_t;

    typedef enum logic [2:0] {
        PH_ADDR, PH_CMD, PH_COUNT, PH_DATA, PH_DONE
    } phase_t;

    logic       scl_s, scl_rise, scl_fall;
    logic       sda_s, sda_rise, sda_fall;
    logic       power_down_n;
    logic       strap_s;

    state_t     state_q, state_d;
    phase_t     phase_q, phase_d;
    logic [7:0] shift_q, shift_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic       byte_mode_q, byte_mode_d;
    logic [6:0] index_q, index_d;
    logic [7:0] remain_q, remain_d;
    logic       ack_q, ack_d;
    logic       tx_first_q, tx_first_d;
    logic       ack_to_tx_q, ack_to_tx_d;
    logic       sda_oe_n_q, sda_oe_n_d;
    logic       armed_q;
    logic       addr_hi_q;
    logic [7:0] regs_q [REG_COUNT];

    // Pins from the bus and the board pass two flops first
    line_sync #(.RESET_VAL(1'b1)) u_scl (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (scl_in),
        .level   (scl_s),
        .rise    (scl_rise),
        .fall    (scl_fall)
    );

    line_sync #(.RESET_VAL(1'b1)) u_sda (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (sda_in),
        .level   (sda_s),
        .rise    (sda_rise),
        .fall    (sda_fall)
    );

    line_sync #(.RESET_VAL(1'b0)) u_pwr (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (power_good_in),
        .level   (power_down_n),
        .rise    (),
        .fall    ()
    );

    line_sync #(.RESET_VAL(1'b1)) u_strap (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (bus_addr_strap),
        .level   (strap_s),
        .rise    (),
        .fall    ()
    );

    // Pin acts as power good until first seen high, then as power down
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            armed_q   <= 1'b0;
            addr_hi_q <= 1'b0;
        end else if (!armed_q && power_down_n) begin
            armed_q   <= 1'b1;
            addr_hi_q <= strap_s;
        end
    end

    // Port control decode
    logic       link_on;
    logic       start_cond;
    logic       stop_cond;
    logic       byte_in;
    logic       addr_match;
    logic       count_phase;
    logic [7:0] rd_data;
    logic [7:0] tx_byte;
    logic       tx_takes_data;
    logic       wr_fire;
    logic       has_room;

    assign link_on      = armed_q & power_down_n;
    assign bus_addr     = addr_hi_q ? ADDR_STRAP_HI
                                    : ADDR_STRAP_LO;
    assign start_cond   = scl_s & sda_fall;
    assign stop_cond    = scl_s & sda_rise;
    assign byte_in      = (state_q == ST_RX) & scl_fall
                          & (bit_cnt_q == BYTE_BITS);
    assign addr_match   = (shift_q[7:1] == bus_addr);
    assign has_room     = byte_mode_q | (remain_q != 8'h00);
    assign count_phase  = tx_first_q & ~byte_mode_q;
    assign tx_takes_data = ~count_phase;
    assign tx_byte      = count_phase ? BLOCK_READ_COUNT : rd_data;

    // Out of range indexes read zero; spread bits come live
    always_comb begin
        rd_data = 8'h00;
        if (index_q < 7'(REG_COUNT)) begin
            rd_data = regs_q[index_q[2:0]];
        end
        if (index_q == 7'(RO_INDEX)) begin
            rd_data = (rd_data & ~RO_MASK)
                      | {6'h00, spread_readback};
        end
    end

    // Writes land once per data byte inside the announced count
    assign wr_fire = byte_in & (phase_q == PH_DATA) & has_room
                     & link_on;

    // Bit engine; received bits shift in on scl rising edges, the data drive moves on falling edges
    always_comb begin
        state_d     = state_q;
        phase_d     = phase_q;
        shift_d     = shift_q;
        bit_cnt_d   = bit_cnt_q;
        byte_mode_d = byte_mode_q;
        index_d     = index_q;
        remain_d    = remain_q;
        ack_d       = ack_q;
        tx_first_d  = tx_first_q;
        ack_to_tx_d = ack_to_tx_q;
        sda_oe_n_d  = sda_oe_n_q;
        if (!link_on) begin
            state_d    = ST_IDLE;
            sda_oe_n_d = 1'b1;
        end else if (start_cond) begin
            state_d    = ST_RX;
            phase_d    = PH_ADDR;
            bit_cnt_d  = 4'h0;
            sda_oe_n_d = 1'b1;
        end else if (stop_cond) begin
            state_d    = ST_IDLE;
            sda_oe_n_d = 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                end
                ST_RX: begin
                    if (scl_rise && bit_cnt_q != BYTE_BITS) begin
                        shift_d   = {shift_q[6:0], sda_s};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (byte_in) begin
                        bit_cnt_d   = 4'h0;
                        state_d     = ST_ACK;
                        sda_oe_n_d  = 1'b0;
                        ack_to_tx_d = 1'b0;
                        case (phase_q)
                            PH_ADDR: begin
                                if (!addr_match) begin
                                    state_d    = ST_IGNORE;
                                    sda_oe_n_d = 1'b1;
                                end else if (shift_q[0]) begin
                                    ack_to_tx_d = 1'b1;
                                    tx_first_d  = 1'b1;
                                end else begin
                                    phase_d = PH_CMD;
                                end
                            end
                            PH_CMD: begin
                                byte_mode_d = shift_q[CMD_MODE_BIT];
                                index_d     = shift_q[6:0];
                                phase_d     = shift_q[CMD_MODE_BIT]
                                              ? PH_DATA : PH_COUNT;
                            end
                            PH_COUNT: begin
                                remain_d = shift_q;
                                phase_d  = PH_DATA;
                            end
                            PH_DATA: begin
                                if (byte_mode_q) begin
                                    phase_d = PH_DONE;
                                end else if (has_room) begin
                                    index_d  = index_q + 7'h01;
                                    remain_d = remain_q - 8'h01;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall && ack_to_tx_q) begin
                        state_d    = ST_TX;
                        shift_d    = tx_byte;
                        sda_oe_n_d = tx_byte[7];
                        bit_cnt_d  = 4'h0;
                        tx_first_d = 1'b0;
                        if (tx_takes_data && !byte_mode_q) begin
                            index_d = index_q + 7'h01;
                        end
                    end else if (scl_fall) begin
                        state_d    = ST_RX;
                        sda_oe_n_d = 1'b1;
                    end
                end
                ST_TX: begin
                    if (scl_fall && bit_cnt_q == 4'h7) begin
                        state_d    = ST_TXACK;
                        sda_oe_n_d = 1'b1;
                    end else if (scl_fall) begin
                        bit_cnt_d  = bit_cnt_q + 4'h1;
                        shift_d    = {shift_q[6:0], 1'b0};
                        sda_oe_n_d = shift_q[6];
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        ack_d = ~sda_s;
                    end else if (scl_fall && ack_q) begin
                        state_d    = ST_TX;
                        shift_d    = tx_byte;
                        sda_oe_n_d = tx_byte[7];
                        bit_cnt_d  = 4'h0;
                        tx_first_d = 1'b0;
                        if (tx_takes_data && !byte_mode_q) begin
                            index_d = index_q + 7'h01;
                        end
                    end else if (scl_fall) begin
                        state_d = ST_IGNORE;
                    end
                end
                ST_IGNORE: begin
                end
                default: begin
                    state_d    = ST_IDLE;
                    sda_oe_n_d = 1'b1;
                end
            endcase
        end
    end

    // Engine state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            phase_q     <= PH_ADDR;
            shift_q     <= 8'h00;
            bit_cnt_q   <= 4'h0;
            byte_mode_q <= 1'b0;
            index_q     <= 7'h00;
            remain_q    <= 8'h00;
            ack_q       <= 1'b0;
            tx_first_q  <= 1'b0;
            ack_to_tx_q <= 1'b0;
            sda_oe_n_q  <= 1'b1;
        end else begin
            state_q     <= state_d;
            phase_q     <= phase_d;
            shift_q     <= shift_d;
            bit_cnt_q   <= bit_cnt_d;
            byte_mode_q <= byte_mode_d;
            index_q     <= index_d;
            remain_q    <= remain_d;
            ack_q       <= ack_d;
            tx_first_q  <= tx_first_d;
            ack_to_tx_q <= ack_to_tx_d;
            sda_oe_n_q  <= sda_oe_n_d;
        end
    end

    // Register file; one entry per loop pass, defaults on reset
    genvar gi;
    generate
        for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
            logic       wr_en;
            logic [7:0] keep_mask;
            assign wr_en     = wr_fire & (index_q == 7'(gi));
            assign keep_mask = (gi == RO_INDEX) ? RO_MASK : 8'h00;
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    regs_q[gi] <= REG_DEFAULTS[gi];
                end else if (wr_en) begin
                    regs_q[gi] <= (shift_q & ~keep_mask)
                                  | (regs_q[gi] & keep_mask);
                end
            end
            assign reg_image[gi*8 +: 8] = regs_q[gi];
        end
    endgenerate

    // Open drain: only ever pulls low, released otherwise
    assign sda_out      = 1'b0;
    assign sda_oe_n     = sda_oe_n_q;
    assign port_enabled = link_on;

endmodule // clkgen_i2c_port

/* File: clkgen_i2c_port_monitor.sv */
`timescale 1ns/100ps

module clkgen_i2c_port_monitor
    import clkgen_i2c_pkg::*;
(
    input wire logic        clk_sys,         // Clock
    input wire logic        rst,             // Reset
    input wire logic        scl_in,          // Serial clock
    input wire logic        sda_in,          // Serial data
    input wire logic        sda_out,         // Drive level
    input wire logic        sda_oe_n,        // Drive enable
    input wire logic        power_good_in,   // Power pin
    input wire logic        bus_addr_strap,  // Strap
    input wire logic [1:0]  spread_readback, // Spread latch
    input wire logic [63:0] reg_image,       // Registers
    input wire logic        port_enabled,    // Port alive
    input wire logic [6:0]  bus_addr         // Address
);
    // Readback bits follow an input, so they stay out of change checks
    localparam logic [63:0] WR_MASK = ~64'h0300;
    logic [63:0] prev_q, dflt;
    logic [7:0]  chg;
    logic        armed_q;
    for (genvar i = 0; i < 8; i++) begin : g_chg
        assign dflt[8*i+:8] = REG_DEFAULTS[i];
        assign chg[i] = (reg_image[8*i+:8] & WR_MASK[8*i+:8])
                        != prev_q[8*i+:8];
    end
    // Image history and arming seen
    always_ff @(posedge clk_sys) begin
        prev_q  <= reg_image & WR_MASK;
        armed_q <= !rst && (armed_q || port_enabled);
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    reset_state_a: assert property (disable iff (1'b0)
        rst |=> reg_image == dflt && sda_oe_n && !port_enabled
        && bus_addr == ADDR_STRAP_LO) else $error("bad reset state");
    drive_low_a: assert property (!sda_oe_n |-> !sda_out)
        else $error("data driven high");
    silent_off_a: assert property (
        (!port_enabled)[*4] |-> sda_oe_n)
        else $error("disabled port drives data");
    power_gate_a: assert property (
        (!power_good_in)[*4] |-> !port_enabled)
        else $error("port alive without power");
    addr_hold_a: assert property (armed_q |-> $stable(bus_addr))
        else $error("address moved after arming");
    addr_pick_a: assert property (port_enabled |->
        bus_addr == ADDR_STRAP_LO || bus_addr == ADDR_STRAP_HI)
        else $error("address not a strap choice");
    oe_timing_a: assert property (
        $changed(sda_oe_n) && port_enabled
        |-> !scl_in && $past(scl_in, 2) == 1'b0)
        else $error("data drive moved with clock high");
    reg_quiet_a: assert property (
        chg != 8'h00 |-> !scl_in && port_enabled)
        else $error("register moved outside a write");
    one_reg_a: assert property ($onehot0(chg))
        else $error("several registers moved at once");
    ack_c: cover property ($fell(sda_oe_n));
    write_c: cover property (chg != 8'h00);
    arm_c: cover property ($rose(port_enabled));
endmodule // clkgen_i2c_port_monitor

/* File: i2c_master_model.sv */
`timescale 1ns/100ps

module i2c_master_model #(
    parameter int QTR = 10  // Quarter bit in clk cycles
) (
    input  wire logic clk_sys,  // Clock
    input  wire logic sda_oe_n, // Device pulls data when low
    output logic      scl_in,   // Serial clock
    output logic      sda_in    // Resolved data line
);
    logic pull_q;
    // Pull-up: a released line reads high, never the last value
    assign sda_in = !pull_q && sda_oe_n;
    initial begin
        scl_in = 1'b1;
        pull_q = 1'b0;
    end
    task automatic q();
        repeat (QTR) @(posedge clk_sys);
    endtask
    // Data moves only with clock low, sampled mid high phase
    task automatic bit_x(input logic b, output logic s);
        pull_q <= !b;
        q();
        scl_in <= 1'b1;
        q();
        @(negedge clk_sys) s = sda_in;
        q();
        scl_in <= 1'b0;
        q();
    endtask
    task automatic start();
        pull_q <= 1'b0;
        q();
        scl_in <= 1'b1;
        q();
        pull_q <= 1'b1;
        q();
        scl_in <= 1'b0;
        q();
    endtask
    task automatic stop();
        pull_q <= 1'b1;
        q();
        scl_in <= 1'b1;
        q();
        pull_q <= 1'b0;
        q();
    endtask
    // Most significant bit first, ack read on the ninth bit
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(d[i], s);
        bit_x(1'b1, s);
        ack = !s;
    endtask
    // Ack all but the last byte, which gets a not-acknowledge
    task automatic recv(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(!ack, s);
    endtask
endmodule // i2c_master_model

/* File: clock_gen_i2c_register_port_tb_top.sv */
`timescale 1ns/100ps

module clock_gen_i2c_register_port_tb_top
    import clkgen_i2c_pkg::*;
;
    logic        clk_sys, rst, power_good_in, bus_addr_strap;
    logic        scl_in, sda_in, sda_out, sda_oe_n, port_enabled;
    logic [1:0]  spread_readback;
    logic [63:0] reg_image;
    logic [6:0]  bus_addr, addr;
    logic [7:0]  exp_q [8];
    logic [31:0] lfsr_q;
    int          err_count, tests_run, cyc;

    clkgen_i2c_port dut_u (.clk_sys(clk_sys), .rst(rst), .scl_in(scl_in),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .power_good_in(power_good_in), .bus_addr_strap(bus_addr_strap),
        .spread_readback(spread_readback), .reg_image(reg_image),
        .port_enabled(port_enabled), .bus_addr(bus_addr));
    i2c_master_model m_u (.clk_sys(clk_sys), .sda_oe_n(sda_oe_n),
        .scl_in(scl_in), .sda_in(sda_in));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = !clk_sys;
    end
    // Timeout cuts a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_count++;
            $display("[FAIL] %0t timeout", $time);
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Fixed seed LFSR keeps every run repeatable
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], ^(s & 32'h80200003)};
    endfunction
    task automatic rnd(output logic [7:0] v);
        lfsr_q = lfsr_next(lfsr_q);
        v = lfsr_q[7:0];
    endtask
    // Expected read value: readback bits come from the spread input
    function automatic logic [7:0] exp_rd(input int i);
        if (i > 7) return 8'h00;
        if (i != RO_INDEX) return exp_q[i];
        return (exp_q[i] & ~RO_MASK) | {6'h00, spread_readback};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Readback bits follow the spread input, so the image skips them
    function automatic logic [7:0] img_mask(input int i);
        return (i == RO_INDEX) ? ~RO_MASK : 8'hFF;
    endfunction
    task automatic chk_img();
        for (int i = 0; i < 8; i++)
            chk(reg_image[8*i+:8] & img_mask(i),
                exp_rd(i) & img_mask(i));
    endtask
    task automatic wr(input logic [7:0] cmd, input int n,
                      input logic [7:0] d [8], input logic sp);
        logic a;
        m_u.start();
        m_u.send({addr, 1'b0}, a);
        chk({7'h0, a}, 8'h01);
        m_u.send(cmd, a);
        chk({7'h0, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            m_u.send(d[i], a);
            chk({7'h0, a}, 8'h01);
        end
        if (sp) m_u.stop();
    endtask
    task automatic rd(input logic [7:0] cmd, input int n,
                      output logic [7:0] d [8]);
        logic a;
        wr(cmd, 0, d, 1'b0);
        m_u.start();
        m_u.send({addr, 1'b1}, a);
        chk({7'h0, a}, 8'h01);
        for (int i = 0; i < n; i++) m_u.recv(i < n - 1, d[i]);
        m_u.stop();
    endtask
    // Address only; refused when disabled or mismatched
    task automatic probe(input logic [6:0] ad, input logic want);
        logic a;
        m_u.start();
        m_u.send({ad, 1'b0}, a);
        chk({7'h0, a}, {7'h0, want});
        m_u.stop();
    endtask

    initial begin
        logic [7:0] d [8];
        logic [7:0] v;
        int         idx, n;
        {rst, power_good_in, bus_addr_strap} = 3'b100;
        {err_count, tests_run, cyc} = '0;
        spread_readback = 2'h0;
        lfsr_q = 32'h3EEC874B;
        for (int p = 0; p < 2; p++) begin
            rst <= 1'b1;
            rnd(v);
            spread_readback <= v[1:0];
            repeat (10) @(posedge clk_sys);
            rst <= 1'b0;
            power_good_in <= 1'b0;
            for (int i = 0; i < 8; i++) exp_q[i] = REG_DEFAULTS[i];
            repeat (20) @(posedge clk_sys);
            chk_img();
            probe(ADDR_STRAP_LO, 1'b0);
            bus_addr_strap <= p[0];
            power_good_in <= 1'b1;
            repeat (20) @(posedge clk_sys);
            addr = p[0] ? ADDR_STRAP_HI : ADDR_STRAP_LO;
            bus_addr_strap <= !p[0];
            probe(p[0] ? ADDR_STRAP_LO : ADDR_STRAP_HI, 1'b0);
            chk({1'b0, bus_addr}, {1'b0, addr});
            // Byte write then byte read of a random register
            for (int k = 0; k < 2; k++) begin
                rnd(v);
                idx = v[2:0];
                rnd(d[0]);
                wr({5'h10, idx[2:0]}, 1, d, 1'b1);
                exp_q[idx] = d[0];
                chk_img();
                rd({5'h10, idx[2:0]}, 1, d);
                chk(d[0], exp_rd(idx));
            end
            // Block write: command zero first, then a random start
            for (int k = 0; k < 2; k++) begin
                rnd(v);
                idx = k ? v[2:0] : 0;
                n = 1 + v[7:3] % 6;
                d[0] = n[7:0];
                for (int i = 1; i <= n; i++) rnd(d[i]);
                wr({1'b0, idx[6:0]}, n + 1, d, 1'b1);
                for (int i = 0; i < n; i++)
                    if (idx + i < 8) exp_q[idx + i] = d[i + 1];
                chk_img();
            end
            // Block read: count byte, then ascending registers
            rnd(v);
            idx = v[2:0];
            rd({1'b0, idx[6:0]}, 4, d);
            chk(d[0], BLOCK_READ_COUNT);
            for (int i = 1; i < 4; i++)
                chk(d[i], exp_rd(idx + i - 1));
            // Power down keeps registers and address
            power_good_in <= 1'b0;
            repeat (10) @(posedge clk_sys);
            chk({7'h0, port_enabled}, 8'h00);
            probe(addr, 1'b0);
            power_good_in <= 1'b1;
            repeat (10) @(posedge clk_sys);
            chk({1'b0, bus_addr}, {1'b0, addr});
            probe(addr, 1'b1);
            chk_img();
        end
        wrap_up();
    end
endmodule // clock_gen_i2c_register_port_tb_top

bind clkgen_i2c_port clkgen_i2c_port_monitor mon_u (.clk_sys(clk_sys),
    .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .power_good_in(power_good_in),
    .bus_addr_strap(bus_addr_strap), .spread_readback(spread_readback),
    .reg_image(reg_image), .port_enabled(port_enabled),
    .bus_addr(bus_addr));
